// ===== design/swd_resp_regs.svh
`ifndef SWD_RESP_REGS_SVH
`define SWD_RESP_REGS_SVH
// How it works
// - CRC failure replies negative ack, no payload
// - Identification reply 0xC0 carries id word
// - Read reply: data, status, two-byte remaining
// - Failed read still fills data; remaining counted
// - Read status: 0 ok, 1 busy, 2 error
// - Length is bytes plus three, MSB first
// - Access status after write or address error
// - Access status: code then two-byte count
// - Rate reply 0xC3 reports current baud
// - Status reply 0xC4 carries two bytes
// - Bits: 8 protected, 7 busy, 6 erasing
// - In reset: bit8 one, bit5 zero
// - Bit 0 set when link reset processor
// - Speed reply 0xC5 carries fast clock count
// - Security fuse blocks memory read and write
// - Flash controller reset counts as secured
// - Good command replies ack 0x40, no payload
// - Unknown command also replies negative ack

// ====================================================
// Wishbone register offsets
`define SWD_REG_CTRL 8'h00
`define SWD_REG_STAT 8'h04
`define SWD_REG_IDCODE 8'h08
`define SWD_REG_BAUD 8'h0C
`define SWD_REG_SPEED 8'h10
`define SWD_REG_TX 8'h14
`define SWD_REG_RESULT 8'h18
`define SWD_REG_RDLEN 8'h1C

// ====================================================
// Control fields
`define SWD_CTRL_CPU_HALT 0
`define SWD_CTRL_LINK_RST 1
`define SWD_CTRL_FUSE 2
`define SWD_CTRL_FC_RST 3
`define SWD_CTRL_ERASE 4
`define SWD_CTRL_BUSY 5
`define SWD_CTRL_SYS_RST 6

// ====================================================
// Frame constants
`define SWD_SYNC 8'h55
`define SWD_RC_ACK 8'h40
`define SWD_RC_NEGATIVE_ACK_REPLY 8'h41
`define SWD_RC_ID 8'hC0
`define SWD_RC_RDATA 8'hC1
`define SWD_RC_ASTAT 8'hC2
`define SWD_RC_BAUD 8'hC3
`define SWD_RC_STAT 8'hC4
`define SWD_RC_SPEED 8'hC5
`define SWD_RD_TRAIL 16'h0003
`define SWD_ST_OK 8'h00
`define SWD_ST_BUSY 8'h01
`define SWD_ST_BERR 8'h02
`define SWD_ST_PROT_BIT 8
`define SWD_ST_BUSY_BIT 7
`define SWD_ST_ERASE_BIT 6
`define SWD_ST_HALT_BIT 5
`define SWD_ST_RST_BIT 0
`define SWD_CRC_POLY 16'h1021
`define SWD_CRC_INIT 16'hFFFF
// Identification word default; value is arbitrary
`define SWD_ID_DEFAULT 32'h0000_0001
`endif

// ===== design/swd_resp_pkg.sv
package swd_resp_pkg;
	typedef enum logic [3:0] {
		SWD_K_ACK = 4'h0,
		SWD_K_NEGATIVE_ACK_REPLY = 4'h1,
		SWD_K_ID = 4'h2,
		SWD_K_RDATA = 4'h3,
		SWD_K_ASTAT = 4'h4,
		SWD_K_BAUD = 4'h5,
		SWD_K_STAT = 4'h6,
		SWD_K_SPEED = 4'h7,
		SWD_K_RDERR = 4'h8,
		SWD_K_BADCMD = 4'h9
	} swd_kind_t;

	typedef enum logic [6:0] {
		SWD_S_IDLE = 7'h01,
		SWD_S_SYNC = 7'h02,
		SWD_S_CODE = 7'h04,
		SWD_S_LEN = 7'h08,
		SWD_S_PAY = 7'h10,
		SWD_S_CRC = 7'h20,
		SWD_S_DONE = 7'h40
	} swd_state_t;
endpackage

// ===== design/swd_resp.sv
// Design decisions made here: the register addresses and register access over Wishbone.
`include "swd_resp_regs.svh"

module swd_resp (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Classic Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Command events from the decoder
	input wire logic cmd_valid,
	input wire logic [3:0] cmd_kind,
	input wire logic cmd_crc_err,
	// Read data stream from the service bus
	input wire logic rd_valid,
	input wire logic [7:0] rd_data,
	input wire logic rd_err,
	input wire logic rd_err_busy,
	// Link byte stream to the transmitter
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	// Memory access permission
	output logic mem_allowed
);

	// ====================================================
	// Register file
	logic [7:0] ctrl_r;
	logic [31:0] id_r;
	logic [15:0] baud_r;
	logic [15:0] speed_r;
	logic [7:0] result_st_r;
	logic [15:0] result_cnt_r;
	logic [15:0] rdlen_r;
	logic [15:0] status_word;
	logic secured;

	// Fuse or flash controller reset both lock memory commands
	assign secured = ctrl_r[`SWD_CTRL_FUSE] | ctrl_r[`SWD_CTRL_FC_RST];

	always_comb begin
		status_word = 16'h0000;
		status_word[`SWD_ST_PROT_BIT] = secured | ctrl_r[`SWD_CTRL_SYS_RST];
		status_word[`SWD_ST_BUSY_BIT] = ctrl_r[`SWD_CTRL_BUSY];
		status_word[`SWD_ST_ERASE_BIT] = ctrl_r[`SWD_CTRL_ERASE];
		status_word[`SWD_ST_HALT_BIT] = ctrl_r[`SWD_CTRL_CPU_HALT] &
			~ctrl_r[`SWD_CTRL_SYS_RST];
		status_word[`SWD_ST_RST_BIT] = ctrl_r[`SWD_CTRL_LINK_RST];
	end

	// ====================================================
	// Wishbone slave
	logic wb_req;
	logic wb_wr;
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// Writes land on the ack edge, while the master still holds its data
	assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r <= 8'h00;
			id_r <= `SWD_ID_DEFAULT;
			baud_r <= 16'h0000;
			speed_r <= 16'h0000;
			rdlen_r <= 16'h0004;
		end else if (wb_wr && wb_sel_i[0]) begin
			case (wb_adr_i)
				`SWD_REG_CTRL: ctrl_r <= wb_dat_i[7:0];
				`SWD_REG_IDCODE: id_r <= wb_dat_i;
				`SWD_REG_BAUD: baud_r <= wb_dat_i[15:0];
				`SWD_REG_SPEED: speed_r <= wb_dat_i[15:0];
				`SWD_REG_RDLEN: rdlen_r <= wb_dat_i[15:0];
				default: ;
			endcase
		end
	end

	// Ack one cycle after request; unmapped reads return zero
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			case (wb_adr_i)
				`SWD_REG_CTRL: wb_dat_o <= {24'h000000, ctrl_r};
				`SWD_REG_STAT: wb_dat_o <= {16'h0000, status_word};
				`SWD_REG_IDCODE: wb_dat_o <= id_r;
				`SWD_REG_BAUD: wb_dat_o <= {16'h0000, baud_r};
				`SWD_REG_SPEED: wb_dat_o <= {16'h0000, speed_r};
				`SWD_REG_RESULT: wb_dat_o <= {8'h00, result_st_r, result_cnt_r};
				`SWD_REG_RDLEN: wb_dat_o <= {16'h0000, rdlen_r};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// ====================================================
	// Memory gate, registered so a control write never glitches it
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			mem_allowed <= 1'b0;
		else
			mem_allowed <= ~secured;
	end

	// ====================================================
	// Reply framer
	swd_resp_pkg::swd_state_t state_r;
	logic [7:0] code_r;
	logic [15:0] len_r;
	logic [15:0] idx_r;
	logic [15:0] crc_r;
	logic [31:0] pay_r;
	logic [1:0] pay_n_r;
	logic is_rd_r;
	logic rd_failed_r;
	logic hi_r;
	logic [7:0] st_byte_r;
	logic [15:0] remain_r;
	logic [7:0] pay_byte;
	logic pay_ready;
	logic [15:0] data_len;
	logic fire;

	assign fire = tx_valid & tx_ready;
	assign data_len = len_r - `SWD_RD_TRAIL;

	// Payload byte for the current index
	always_comb begin
		pay_byte = 8'h00;
		pay_ready = 1'b1;
		if (is_rd_r) begin
			if (idx_r < data_len) begin
				// The failing byte and all after it go out as zero padding
				pay_byte = (rd_failed_r || !rd_valid) ? 8'h00 : rd_data;
				pay_ready = rd_failed_r | rd_valid | rd_err;
			end else if (idx_r == data_len) begin
				pay_byte = st_byte_r;
			end else if (idx_r == data_len + 16'h0001) begin
				pay_byte = remain_r[15:8];
			end else begin
				pay_byte = remain_r[7:0];
			end
		end else begin
			case (pay_n_r)
				2'd0: pay_byte = pay_r[31:24];
				2'd1: pay_byte = pay_r[23:16];
				2'd2: pay_byte = pay_r[15:8];
				default: pay_byte = pay_r[7:0];
			endcase
		end
	end

	// Live read error during data phase sets status and remaining count
	logic rd_hit_err;
	assign rd_hit_err = is_rd_r && !rd_failed_r && state_r == swd_resp_pkg::SWD_S_PAY &&
		idx_r < data_len && !rd_valid && rd_err;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] x;
		x = c;
		for (int i = 7; i >= 0; i--) begin
			x = (x[15] ^ d[i]) ? ((x << 1) ^ `SWD_CRC_POLY) : (x << 1);
		end
		return x;
	endfunction

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= swd_resp_pkg::SWD_S_IDLE;
			code_r <= 8'h00;
			len_r <= 16'h0000;
			idx_r <= 16'h0000;
			pay_r <= 32'h0000_0000;
			pay_n_r <= 2'd0;
			is_rd_r <= 1'b0;
			rd_failed_r <= 1'b0;
			st_byte_r <= 8'h00;
			remain_r <= 16'h0000;
			hi_r <= 1'b0;
		end else begin
			case (state_r)
				swd_resp_pkg::SWD_S_IDLE: begin
					if (cmd_valid) begin
						state_r <= swd_resp_pkg::SWD_S_SYNC;
						idx_r <= 16'h0000;
						pay_n_r <= 2'd0;
						is_rd_r <= 1'b0;
						rd_failed_r <= 1'b0;
						st_byte_r <= `SWD_ST_OK;
						remain_r <= 16'h0000;
						len_r <= 16'h0000;
						if (cmd_crc_err) begin
							code_r <= `SWD_RC_NEGATIVE_ACK_REPLY;
						end else begin
							case (cmd_kind)
								4'(swd_resp_pkg::SWD_K_ACK): code_r <= `SWD_RC_ACK;
								4'(swd_resp_pkg::SWD_K_ID): begin
									code_r <= `SWD_RC_ID;
									len_r <= 16'h0004;
									pay_r <= id_r;
								end
								4'(swd_resp_pkg::SWD_K_RDATA): begin
									if (secured) begin
										code_r <= `SWD_RC_NEGATIVE_ACK_REPLY;
									end else begin
										code_r <= `SWD_RC_RDATA;
										len_r <= rdlen_r + `SWD_RD_TRAIL;
										is_rd_r <= 1'b1;
									end
								end
								4'(swd_resp_pkg::SWD_K_ASTAT),
								4'(swd_resp_pkg::SWD_K_RDERR): begin
									code_r <= secured ? `SWD_RC_NEGATIVE_ACK_REPLY : `SWD_RC_ASTAT;
									len_r <= secured ? 16'h0000 : 16'h0003;
									pay_r <= {result_st_r, result_cnt_r, 8'h00};
								end
								4'(swd_resp_pkg::SWD_K_BAUD): begin
									code_r <= `SWD_RC_BAUD;
									len_r <= 16'h0002;
									pay_r <= {baud_r, 16'h0000};
								end
								4'(swd_resp_pkg::SWD_K_STAT): begin
									code_r <= `SWD_RC_STAT;
									len_r <= 16'h0002;
									pay_r <= {status_word, 16'h0000};
								end
								4'(swd_resp_pkg::SWD_K_SPEED): begin
									code_r <= `SWD_RC_SPEED;
									len_r <= 16'h0002;
									pay_r <= {speed_r, 16'h0000};
								end
								default: code_r <= `SWD_RC_NEGATIVE_ACK_REPLY;
							endcase
						end
					end
				end
				swd_resp_pkg::SWD_S_SYNC: begin
					if (fire)
						state_r <= swd_resp_pkg::SWD_S_CODE;
				end
				swd_resp_pkg::SWD_S_CODE: begin
					if (fire) begin
						state_r <= swd_resp_pkg::SWD_S_LEN;
						hi_r <= 1'b1;
					end
				end
				swd_resp_pkg::SWD_S_LEN: begin
					if (fire) begin
						hi_r <= 1'b0;
						if (!hi_r)
							state_r <= (len_r == 16'h0000) ? swd_resp_pkg::SWD_S_CRC :
								swd_resp_pkg::SWD_S_PAY;
						if (!hi_r && len_r == 16'h0000)
							hi_r <= 1'b1;
					end
				end
				swd_resp_pkg::SWD_S_PAY: begin
					if (rd_hit_err) begin
						rd_failed_r <= 1'b1;
						st_byte_r <= rd_err_busy ? `SWD_ST_BUSY : `SWD_ST_BERR;
						// Remaining counts from the failing byte to the payload end, trailer bytes included
						remain_r <= len_r - idx_r;
					end
					if (fire) begin
						idx_r <= idx_r + 16'h0001;
						pay_n_r <= pay_n_r + 2'd1;
						if (idx_r + 16'h0001 == len_r) begin
							state_r <= swd_resp_pkg::SWD_S_CRC;
							hi_r <= 1'b1;
						end
					end
				end
				swd_resp_pkg::SWD_S_CRC: begin
					if (fire) begin
						hi_r <= 1'b0;
						if (!hi_r)
							state_r <= swd_resp_pkg::SWD_S_DONE;
					end
				end
				swd_resp_pkg::SWD_S_DONE: state_r <= swd_resp_pkg::SWD_S_IDLE;
				default: state_r <= swd_resp_pkg::SWD_S_IDLE;
			endcase
		end
	end

	// ====================================================
	// Last access outcome, latched for the next access status reply
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			result_st_r <= `SWD_ST_OK;
			result_cnt_r <= 16'h0000;
		end else if (wb_wr && wb_adr_i == `SWD_REG_RESULT) begin
			result_st_r <= wb_dat_i[23:16];
			result_cnt_r <= wb_dat_i[15:0];
		end
	end

	// ====================================================
	// Byte output and CRC; tx is decoded combinationally from the framer state
	logic [7:0] next_byte;
	logic next_valid;
	always_comb begin
		next_byte = 8'h00;
		next_valid = 1'b1;
		case (state_r)
			swd_resp_pkg::SWD_S_SYNC: next_byte = `SWD_SYNC;
			swd_resp_pkg::SWD_S_CODE: next_byte = code_r;
			swd_resp_pkg::SWD_S_LEN: next_byte = hi_r ? len_r[15:8] : len_r[7:0];
			swd_resp_pkg::SWD_S_PAY: begin
				next_byte = pay_byte;
				next_valid = pay_ready;
			end
			swd_resp_pkg::SWD_S_CRC: next_byte = hi_r ? crc_r[15:8] : crc_r[7:0];
			default: next_valid = 1'b0;
		endcase
	end

	// Combinational view of the stream; rd_data is consumed on fire
	always_comb begin
		tx_data = next_byte;
		tx_valid = next_valid;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			crc_r <= `SWD_CRC_INIT;
		else if (state_r == swd_resp_pkg::SWD_S_IDLE)
			crc_r <= `SWD_CRC_INIT;
		else if (fire && state_r != swd_resp_pkg::SWD_S_CRC)
			crc_r <= crc_step(crc_r, next_byte);
	end

endmodule

// ===== sim/swd_resp_assertions.sv
`include "swd_resp_regs.svh"

module swd_resp_chk (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	// Reply stream and gate
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic mem_allowed
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// ==========
	// Frame tracker: counts taken bytes, so a stalled read never looks like a new frame
	logic in_r;
	logic [15:0] pos_r;
	logic [15:0] flen_r;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			in_r <= 1'b0;
			pos_r <= 16'h0000;
			flen_r <= 16'h0000;
		end else if (tx_valid && tx_ready) begin
			pos_r <= in_r ? pos_r + 16'h0001 : 16'h0001;
			in_r <= !(in_r && pos_r > 16'h0003 && pos_r == flen_r + 16'h0005);
			if (in_r && pos_r == 16'h0002)
				flen_r[15:8] <= tx_data;
			if (in_r && pos_r == 16'h0003)
				flen_r[7:0] <= tx_data;
		end
	end
	sequence sync_hs;
		!in_r && tx_valid && tx_ready;
	endsequence
	sequence ctl_wr;
		wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == `SWD_REG_CTRL && wb_sel_i[0];
	endsequence
	// ==========
	// Checks
	ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("wishbone ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("wishbone ack too long");
	ack_drop_a: assert property (!wb_stb_i |=> !wb_ack_o)
		else $error("ack without request");
	byte_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("stalled byte changed");
	sync_first_a: assert property (tx_valid && !in_r |-> tx_data == `SWD_SYNC)
		else $error("frame not opened by sync");
	code_ok_a: assert property (sync_hs |=> tx_valid && tx_data inside {
		8'h40, 8'h41, 8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5})
		else $error("bad reply code");
	empty_len_a: assert property (sync_hs ##[1:3] (tx_ready &&
		tx_data inside {8'h40, 8'h41}) |=> tx_data == 8'h00)
		else $error("ack length high not zero");
	mem_gate_a: assert property (ctl_wr |-> ##2 mem_allowed ==
		!($past(wb_dat_i[2], 2) || $past(wb_dat_i[3], 2)))
		else $error("memory gate wrong");
endmodule

bind swd_resp swd_resp_chk chk_u (.*);

// ===== sim/swd_link_master.sv
module swd_link_master (
	// Clock
	input wire logic core_clk,
	// Reply byte stream
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Stalls one cycle in three so held bytes get exercised
	logic [7:0] got[$];
	int n_r = 0;
	logic [1:0] ph_r = 2'h0;
	always @(posedge core_clk) begin
		ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
		tx_ready <= ph_r != 2'h1;
		if (tx_valid && tx_ready) begin
			got.push_back(tx_data);
			n_r <= n_r + 1;
		end
	end
endmodule

// ===== sim/swd_resp_bench.sv
`include "swd_resp_regs.svh"

module swd_resp_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Signals
	logic core_clk = 0, reset_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
	logic cmd_valid = 0, cmd_crc_err = 0, rd_valid = 1, rd_err = 0, rd_err_busy = 0;
	logic tx_valid, tx_ready, mem_allowed;
	logic [7:0] wb_adr_i = 0, rd_data = 8'hA5, tx_data;
	logic [3:0] cmd_kind = 0, wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 0, wb_dat_o, q;
	logic [7:0] pay[$];
	logic [7:0] ctl_v [7] = '{8'h01, 8'h02, 8'h10, 8'h20, 8'h41, 8'h04, 8'h08};
	logic [15:0] st_v [7] = '{16'h0020, 16'h0001, 16'h0040, 16'h0080, 16'h0100, 16'h0100,
		16'h0100};
	int num_errors = 0, n_tests = 0, base = 0, err_at = 0;
	always #5 core_clk = ~core_clk;
	swd_resp dut_u (.*);
	swd_link_master pm_u (.*);
	// ==========
	// Tasks
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int i;
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 50);
		q = wb_dat_o;
		if (i >= 50)
			num_errors++;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge core_clk);
	endtask
	function automatic logic [15:0] crc(input logic [7:0] b[$]);
		logic [15:0] c;
		c = `SWD_CRC_INIT;
		foreach (b[i])
			for (int k = 7; k >= 0; k--)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][k]) ? `SWD_CRC_POLY : 16'h0000);
		return c;
	endfunction
	// Bytes past a prefix stay unchecked where the payload width is not fixed
	task automatic reply(input logic [3:0] k, input logic e, input logic [7:0] code, input bit full);
		logic [7:0] x[$];
		logic [15:0] c;
		int i;
		x = {8'h55, code};
		if (full) begin
			x = {x, 8'h00, 8'(pay.size()), pay};
			c = crc(x);
			x = {x, c[15:8], c[7:0]};
		end
		base = pm_u.n_r;
		cmd_valid <= 1;
		cmd_kind <= k;
		cmd_crc_err <= e;
		@(posedge core_clk);
		cmd_valid <= 0;
		i = 0;
		while ((pm_u.n_r - base < x.size() || tx_valid === 1'b1) && i < 500) begin
			@(posedge core_clk);
			i++;
		end
		foreach (x[j]) check("reply byte", pm_u.got[base + j], x[j]);
		err_at = 0;
		rd_err <= 0;
		rd_valid <= 1;
		repeat (2) @(posedge core_clk);
	endtask
	// Fail the service read right after byte err_at of the frame is taken
	// Service read data follows the frame index, so byte order is visible
	always @(posedge core_clk)
		if (tx_valid && tx_ready) begin
			rd_data <= 8'(8'hA1 + pm_u.n_r - base);
			if (err_at != 0 && pm_u.n_r - base == err_at - 1) begin
				rd_err <= 1;
				rd_valid <= 0;
			end
		end
	// ==========
	// Tests
	initial begin
		repeat (12) @(posedge core_clk);
		reset_n <= 1;
		@(posedge core_clk);
		wb(0, 8'hF0, 0);
		check("unmapped", q, 0);
		foreach (ctl_v[i]) begin
			wb(1, `SWD_REG_CTRL, ctl_v[i]);
			wb(0, `SWD_REG_STAT, 0);
			check("status", q, st_v[i]);
			check("mem gate", mem_allowed, !(ctl_v[i][2] | ctl_v[i][3]));
		end
		$display("test status word done");
		reply(3, 0, 8'h41, 1);
		wb(1, `SWD_REG_CTRL, 32'h04);
		reply(4, 0, 8'h41, 1);
		wb(1, `SWD_REG_CTRL, 32'h01);
		wb(1, `SWD_REG_RESULT, 32'h00020005);
		reply(0, 0, 8'h40, 1);
		reply(2, 1, 8'h41, 1);
		reply(9, 0, 8'h41, 1);
		reply(1, 0, 8'h41, 1);
		pay = {8'h00, 8'h00, 8'h00, 8'h01};
		reply(2, 0, 8'hC0, 1);
		pay = {8'h00, 8'h20};
		reply(6, 0, 8'hC4, 1);
		pay = {8'h02, 8'h00, 8'h05};
		reply(4, 0, 8'hC2, 1);
		reply(8, 0, 8'hC2, 1);
		wb(1, `SWD_REG_BAUD, 32'h1234);
		pay = {8'h12, 8'h34};
		reply(5, 0, 8'hC3, 1);
		wb(1, `SWD_REG_SPEED, 32'h00AB);
		pay = {8'h00, 8'hAB};
		reply(7, 0, 8'hC5, 1);
		pay = {8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'h00, 8'h00, 8'h00};
		reply(3, 0, 8'hC1, 1);
		err_at = 6;
		pay = {8'hA4, 8'hA5, 8'h00, 8'h00, 8'h02, 8'h00, 8'h05};
		reply(3, 0, 8'hC1, 1);
		err_at = 4;
		rd_err_busy <= 1;
		pay = {8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h07};
		reply(3, 0, 8'hC1, 1);
		$display("test replies done");
		give_verdict();
	end
	initial begin
		#300000;
		num_errors++;
		give_verdict();
	end
endmodule
